/* bench/dhmc_chk.sv */
// checker for the homing-mode link, watching the four process-data words
// assumes the bench instantiates it beside the link interface, no bind
`timescale 1ns/10ps
module dhmc_chk (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // link words
   input wire logic [15:0] I_CTRL_WORD,
   input wire logic [15:0] I_MODE_SEL,
   input wire logic [15:0] I_STAT_WORD,
   input wire logic [15:0] I_MODE_DISP
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // three samples cover the state edge plus the status edge
   sequence held(logic [15:0] v);
      (I_CTRL_WORD == v)[*3];
   endsequence
   sequence enabled_held;
      (I_CTRL_WORD[3:0] == 4'hF && !I_CTRL_WORD[7])[*3];
   endsequence
   disp_echo_a: assert property ($past(I_RST_N) |-> I_MODE_DISP == $past(I_MODE_SEL))
      else $error("mode display not echoed");
   seq_off_a: assert property (held(16'h0000) |-> (I_STAT_WORD & 16'h007F) == 16'h0050)
      else $error("no switch-on disabled status");
   seq_ready_a: assert property (held(16'h0006) |-> (I_STAT_WORD & 16'h007F) == 16'h0031)
      else $error("no ready status");
   seq_swon_a: assert property (held(16'h0007) |-> (I_STAT_WORD & 16'h007F) == 16'h0033)
      else $error("no switched on status");
   op_enabled_a: assert property (enabled_held |-> (I_STAT_WORD & 16'h007F) == 16'h0037)
      else $error("operation not enabled");
   // a start from 0007 waits one edge for the enabled state, so flags clear on the third sample
   start_clear_a: assert property ($rose(I_CTRL_WORD[4]) |-> ##3 I_STAT_WORD[13:12] == 2'b00)
      else $error("start did not clear homing flags");
   flag_excl_a: assert property (I_STAT_WORD[13] |-> !I_STAT_WORD[12])
      else $error("error and attained together");
   attained_a: assert property ($rose(I_STAT_WORD[12]) |->
      I_CTRL_WORD[4] && (I_STAT_WORD & 16'h007F) == 16'h0037)
      else $error("attained outside enabled homing");
   mode_guard_a: assert property ($changed(I_MODE_SEL) |-> I_CTRL_WORD == 16'h0000 ||
      (I_CTRL_WORD == 16'h0007 && (I_STAT_WORD & 16'h007F) == 16'h0033))
      else $error("mode changed outside switched on");
endmodule // dhmc_chk

/* bench/drive_homing_mode_control_tb.sv */
// self-checking bench: both link ends joined, apb driven, axis feedback by hand
// assumes package and link interface are compiled first
`timescale 1ns/10ps
module drive_homing_mode_control_tb
   import dhmc_pkg::*;
;
   logic clk, rst_n, psel, penable, pwrite, found, still, fail, irq, run, decel, pwr, slverr, rdy;
   logic [7:0] paddr, method;
   logic [31:0] pwdata, prdata, r;
   logic [2:0] flags;
   int bad_count, cmp_count;
   dhmc_link_if dhmc_link_if_i ();
   dhmc_drive dhmc_drive_i (.I_CLK(clk), .I_RST_N(rst_n), .LINK(dhmc_link_if_i),
      .I_HOME_METHOD(method), .I_HOME_FOUND(found), .I_AXIS_STILL(still), .I_HOME_FAIL(fail),
      .I_FAULT(1'b0), .I_WARN(flags[0]), .I_WARN2(flags[1]), .I_LIMIT(flags[2]),
      .O_RUN_HOMING(run), .O_DECEL_HOMING(decel), .O_POWER_ON(pwr));
   dhmc_plc dhmc_plc_i (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(rdy), .O_PSLVERR(slverr), .O_IRQ(irq), .LINK(dhmc_link_if_i));
   dhmc_chk dhmc_chk_i (.I_CLK(clk), .I_RST_N(rst_n), .I_CTRL_WORD(dhmc_link_if_i.ctrl_word),
      .I_MODE_SEL(dhmc_link_if_i.mode_sel), .I_STAT_WORD(dhmc_link_if_i.stat_word),
      .I_MODE_DISP(dhmc_link_if_i.mode_disp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic give_up();
      $display("MISMATCH %0t wait expired", $time);
      bad_count++;
      complete_run();
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask
   // request held until the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) give_up();
      r = prdata;
      check(32'(slverr), 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(r, e);
   endtask
   // status is polled, never assumed; the loop bound is the hang guard
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, DHMC_A_STATUS, 32'h0);
         n++;
      end while ((r & m) !== v && n < 40);
      if ((r & m) !== v) give_up();
   endtask
   task automatic stop_run();
      apb(1'b1, DHMC_A_CMD, 32'h3);
      poll(32'h006F, 32'h0023);
   endtask
   task automatic t_reset();
      rd(DHMC_A_STATUS, 32'h0050);
      rd(DHMC_A_DISP, 32'h0006);
      rd(DHMC_A_IRQ, 32'h0);
      rd(8'h1C, 32'h0);
   endtask
   task automatic t_power();
      apb(1'b1, DHMC_A_CMD, 32'h1);
      poll(32'hFFFF, 32'h0037);
      rd(DHMC_A_CMD, 32'h000F);
      check(32'(pwr), 32'h1);
      flags <= 3'b111;
      poll(32'h8880, 32'h8880);
      check(r, 32'h88B7);
      flags <= 3'b000;
      apb(1'b1, DHMC_A_MODE, 32'h1);
      rd(DHMC_A_MODE, 32'h6);
   endtask
   task automatic t_table();
      stop_run();
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, DHMC_A_MODE, (i == 0) ? 32'h1 : 32'h6);
         method <= (i == 1) ? 8'h00 : 8'h05;
         rd(DHMC_A_DISP, (i == 0) ? 32'h1 : 32'h6);
         apb(1'b1, DHMC_A_CMD, 32'h2);
         repeat (3) @(posedge clk);
         check(32'(run), (i == 2) ? 32'h1 : 32'h0);
         stop_run();
         check(32'(run), 32'h0);
      end
   endtask
   task automatic t_home();
      apb(1'b1, DHMC_A_MASK, 32'h1);
      apb(1'b1, DHMC_A_CMD, 32'h2);
      rd(DHMC_A_CMD, 32'h001F);
      found <= 1'b1;
      poll(32'h1000, 32'h1000);
      check(r, 32'h1437);
      check(32'(irq), 32'h1);
      rd(DHMC_A_IRQ, 32'h5);
      rd(DHMC_A_IRQ, 32'h0);
      check(32'(irq), 32'h0);
      found <= 1'b0;
   endtask
   task automatic t_error();
      stop_run();
      apb(1'b1, DHMC_A_CMD, 32'h2);
      repeat (3) @(posedge clk);
      fail <= 1'b1;
      poll(32'h2000, 32'h2000);
      check(r & 32'h3000, 32'h2000);
      check(32'(irq), 32'h0);
      apb(1'b1, DHMC_A_MASK, 32'h2);
      @(posedge clk);
      check(32'(irq), 32'h1);
      rd(DHMC_A_IRQ, 32'h2);
      fail <= 1'b0;
   endtask
   task automatic t_halt();
      stop_run();
      apb(1'b1, DHMC_A_CMD, 32'h6);
      rd(DHMC_A_CMD, 32'h011F);
      poll(32'h046F, 32'h0027);
      check({30'h0, run, decel}, 32'h1);
      still <= 1'b1;
      poll(32'h046F, 32'h0427);
      stop_run();
      check(32'(decel), 32'h0);
   endtask
   initial begin
      bad_count = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      {psel, penable, pwrite, found, still, fail} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      method = 8'h05;
      flags = 3'b000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_power();
      t_table();
      t_home();
      t_error();
      t_halt();
      complete_run();
   end
endmodule // drive_homing_mode_control_tb

/* verilog/dhmc_drive.sv */
// drive end: power state machine and homing state, answered as status word
// assumes motion feedback (home found, speed zero, error) from the axis logic
`timescale 1ns/10ps
module dhmc_drive
   import dhmc_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // process-data link
   dhmc_link_if.drive LINK,
   // configuration
   input wire logic [7:0] I_HOME_METHOD,
   // axis feedback
   input wire logic I_HOME_FOUND,
   input wire logic I_AXIS_STILL,
   input wire logic I_HOME_FAIL,
   input wire logic I_FAULT,
   input wire logic I_WARN,
   input wire logic I_WARN2,
   input wire logic I_LIMIT,
   // axis commands
   output logic O_RUN_HOMING,
   output logic O_DECEL_HOMING,
   output logic O_POWER_ON
);
   typedef enum logic [2:0] {DHMC_S_SWDIS, DHMC_S_READY, DHMC_S_SWON, DHMC_S_OPEN,
      DHMC_S_QSTOP, DHMC_S_FAULT} dhmc_pst_t;
   dhmc_pst_t st_q, st_d;
   logic homing_q, homing_d, att_q, att_d, herr_q, herr_d, b4_q, b4_d;
   logic [15:0] sw_q, sw_d, disp_q, disp_d;
   logic [15:0] cw;
   logic run_ok, halt;

   assign cw = LINK.ctrl_word;
   // motion changes only under the enable pattern, homing mode and a method set
   assign run_ok = (st_q == DHMC_S_OPEN) && cw[DHMC_CB_ENOP] && (LINK.mode_sel == DHMC_MODE_HOMING)
      && (I_HOME_METHOD != 8'h00);
   assign halt = cw[DHMC_CB_HALT];

   always_comb begin
      st_d = st_q;
      // state transitions from the control bits
      unique case (st_q)
         DHMC_S_SWDIS: if (cw[DHMC_CB_VOLT] && cw[DHMC_CB_QSTOP_N] && !cw[DHMC_CB_ON]) st_d = DHMC_S_READY;
         DHMC_S_READY: begin
            if (!cw[DHMC_CB_VOLT] || !cw[DHMC_CB_QSTOP_N]) st_d = DHMC_S_SWDIS;
            else if (cw[DHMC_CB_ON]) st_d = DHMC_S_SWON;
         end
         DHMC_S_SWON: begin
            if (!cw[DHMC_CB_VOLT] || !cw[DHMC_CB_QSTOP_N]) st_d = DHMC_S_SWDIS;
            else if (!cw[DHMC_CB_ON]) st_d = DHMC_S_READY;
            else if (cw[DHMC_CB_ENOP]) st_d = DHMC_S_OPEN;
         end
         DHMC_S_OPEN: begin
            if (!cw[DHMC_CB_VOLT]) st_d = DHMC_S_SWDIS;
            else if (!cw[DHMC_CB_QSTOP_N]) st_d = DHMC_S_QSTOP;
            else if (!cw[DHMC_CB_ON]) st_d = DHMC_S_READY;
            else if (!cw[DHMC_CB_ENOP]) st_d = DHMC_S_SWON;
         end
         DHMC_S_QSTOP: if (!cw[DHMC_CB_VOLT] || I_AXIS_STILL) st_d = DHMC_S_SWDIS;
         DHMC_S_FAULT: if (cw[DHMC_CB_FRST]) st_d = DHMC_S_SWDIS;
      endcase
      if (I_FAULT) st_d = DHMC_S_FAULT;
   end

   always_comb begin
      // bit 4 is armed only while running is allowed, so 0007 to 001F still starts
      b4_d = cw[DHMC_CB_START] && run_ok;
      homing_d = homing_q;
      att_d = att_q;
      herr_d = herr_q;
      if (!run_ok || !cw[DHMC_CB_START]) begin
         homing_d = 1'b0; // bit 4 falling or leaving enable cancels
      end else if (!b4_q) begin
         homing_d = 1'b1; // rising edge of bit 4 starts
         att_d = 1'b0;
         herr_d = 1'b0;
      end else if (homing_q && I_HOME_FAIL) begin
         homing_d = 1'b0;
         herr_d = 1'b1;
      end else if (homing_q && I_HOME_FOUND && !halt) begin
         homing_d = 1'b0;
         att_d = 1'b1;
      end
      if (st_q == DHMC_S_FAULT && cw[DHMC_CB_FRST]) herr_d = 1'b0;
   end

   always_comb begin
      sw_d = 16'h0000;
      // state word 0050, 0031, 0033, nn37
      unique case (st_q)
         DHMC_S_SWDIS: sw_d[DHMC_SB_SWDIS] = 1'b1;
         DHMC_S_READY: sw_d[DHMC_SB_READY] = 1'b1;
         DHMC_S_SWON: sw_d[DHMC_SB_SWON:DHMC_SB_READY] = 2'h3;
         DHMC_S_OPEN: sw_d[DHMC_SB_OPEN:DHMC_SB_READY] = 3'h7;
         DHMC_S_QSTOP: sw_d[DHMC_SB_OPEN:DHMC_SB_READY] = 3'h7;
         DHMC_S_FAULT: sw_d[DHMC_SB_FAULT] = 1'b1;
      endcase
      sw_d[DHMC_SB_QSTOP_N] = (st_q != DHMC_S_QSTOP) && (st_q != DHMC_S_SWDIS)
         && (st_q != DHMC_S_FAULT);
      sw_d[DHMC_SB_VOLT] = (st_q != DHMC_S_FAULT); // 0050 when switch-on disabled
      sw_d[DHMC_SB_WARN] = I_WARN;
      sw_d[DHMC_SB_REMOTE] = 1'b0;
      sw_d[DHMC_SB_LIMIT] = I_LIMIT;
      sw_d[DHMC_SB_WARN2] = I_WARN2;
      // halted: speed zero; running: home position reached
      sw_d[DHMC_SB_TARGET] = halt ? I_AXIS_STILL : att_q;
      sw_d[DHMC_SB_ATTAINED] = att_q;
      sw_d[DHMC_SB_HERR] = herr_q;
      disp_d = LINK.mode_sel;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         st_q <= DHMC_S_SWDIS;
         homing_q <= 1'b0;
         att_q <= 1'b0;
         herr_q <= 1'b0;
         b4_q <= 1'b0;
         sw_q <= 16'h0000;
         disp_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         homing_q <= homing_d;
         att_q <= att_d;
         herr_q <= herr_d;
         b4_q <= b4_d;
         sw_q <= sw_d;
         disp_q <= disp_d;
      end
   end

   assign LINK.stat_word = sw_q;
   assign LINK.mode_disp = disp_q;
   // halt decelerates with homing ramp and stays enabled
   assign O_RUN_HOMING = homing_q && !halt;
   assign O_DECEL_HOMING = homing_q && halt;
   assign O_POWER_ON = (st_q == DHMC_S_OPEN) || (st_q == DHMC_S_QSTOP);
endmodule // dhmc_drive

/* verilog/dhmc_link_if.sv */
// process-data link between controller and drive; one word pair each
// assumes both ends share the clock and sample the words every cycle
`timescale 1ns/10ps
interface dhmc_link_if;
   logic [15:0] ctrl_word;
   logic [15:0] mode_sel;
   logic [15:0] stat_word;
   logic [15:0] mode_disp;
   modport drive (input ctrl_word, input mode_sel, output stat_word, output mode_disp);
   modport plc (output ctrl_word, output mode_sel, input stat_word, input mode_disp);
endinterface

/* verilog/dhmc_pkg.sv */
// constants shared by both ends of the homing-mode control link
// assumes one 100 MHz clock and one process-data word pair per link cycle
// Notes on behaviour
// - mode word value 6 selects homing
// - mode display echoes selected mode
// - homing method from configuration, zero means none
// - control bit 4 rising edge starts homing
// - halt bit decelerates, stays operation enabled
// - status bit 10: reached, or zero speed
// - status bit 12 set when homing completed
// - status bit 13 set on homing error
// - power-up sequence 0000,0006,0007,000F with answers
// - after 001F report 1n37 when attained
// - motion changes only under enable pattern
// - controller changes mode only under 0007, or under 0000 while its sequence is idle
// - controller checks status 0xnn33 before mode change under 0007
// - control bits: on, voltage, quick stop, enable, fault reset
// - status bits as standard state word
package dhmc_pkg;
   localparam logic [15:0] DHMC_MODE_HOMING = 16'h0006;
   localparam logic [15:0] DHMC_CW_DISABLE = 16'h0000;
   localparam logic [15:0] DHMC_CW_SHUTDOWN = 16'h0006;
   localparam logic [15:0] DHMC_CW_SWITCH_ON = 16'h0007;
   localparam logic [15:0] DHMC_CW_ENABLE = 16'h000F;
   localparam logic [15:0] DHMC_CW_START = 16'h001F;
   localparam logic [15:0] DHMC_CW_HALT = 16'h0100;
   localparam logic [15:0] DHMC_CW_FAULT_RST = 16'h0080;
   // bits 6..0 of the state word tell the power states apart
   localparam logic [15:0] DHMC_SW_READY_MASK = 16'h007F;
   localparam logic [15:0] DHMC_SW_READY_ON = 16'h0031;
   localparam logic [15:0] DHMC_SW_OPEN_MASK = 16'h0037;
   localparam logic [15:0] DHMC_SW_SWITCHED_ON = 16'h0033;
   // control bit positions
   localparam int DHMC_CB_ON = 0;
   localparam int DHMC_CB_VOLT = 1;
   localparam int DHMC_CB_QSTOP_N = 2;
   localparam int DHMC_CB_ENOP = 3;
   localparam int DHMC_CB_START = 4;
   localparam int DHMC_CB_FRST = 7;
   localparam int DHMC_CB_HALT = 8;
   // status bit positions
   localparam int DHMC_SB_READY = 0;
   localparam int DHMC_SB_SWON = 1;
   localparam int DHMC_SB_OPEN = 2;
   localparam int DHMC_SB_FAULT = 3;
   localparam int DHMC_SB_VOLT = 4;
   localparam int DHMC_SB_QSTOP_N = 5;
   localparam int DHMC_SB_SWDIS = 6;
   localparam int DHMC_SB_WARN = 7;
   localparam int DHMC_SB_REMOTE = 9;
   localparam int DHMC_SB_TARGET = 10;
   localparam int DHMC_SB_LIMIT = 11;
   localparam int DHMC_SB_ATTAINED = 12;
   localparam int DHMC_SB_HERR = 13;
   localparam int DHMC_SB_WARN2 = 15;
   // register map of the controller end (APB byte addresses)
   localparam logic [7:0] DHMC_A_CMD = 8'h00;
   localparam logic [7:0] DHMC_A_MODE = 8'h04;
   localparam logic [7:0] DHMC_A_STATUS = 8'h08;
   localparam logic [7:0] DHMC_A_DISP = 8'h0C;
   localparam logic [7:0] DHMC_A_IRQ = 8'h10;
   localparam logic [7:0] DHMC_A_MASK = 8'h14;
   // event bits: 0 attained rise, 1 error rise, 2 target rise, 3 fault rise
   localparam int DHMC_NEV = 4;
   typedef enum logic [1:0] {DHMC_OP_NONE, DHMC_OP_SEQ, DHMC_OP_START, DHMC_OP_STOP} dhmc_op_t;
endpackage

/* verilog/dhmc_plc.sv */
// controller end: APB registers command the drive through the link
// assumes an APB master on the same clock; status arrives one word per cycle
`timescale 1ns/10ps
module dhmc_plc
   import dhmc_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // interrupt
   output logic O_IRQ,
   // process-data link
   dhmc_link_if.plc LINK
);
   typedef enum logic [2:0] {DHMC_Q_IDLE, DHMC_Q_OFF, DHMC_Q_SHUT, DHMC_Q_SWON, DHMC_Q_EN} dhmc_seq_t;
   dhmc_seq_t sq_q, sq_d;
   logic [15:0] cw_q, cw_d, mode_q, mode_d;
   logic [DHMC_NEV-1:0] irq_q, irq_d, mask_q, mask_d, ev, prev_q, prev_d;
   logic [31:0] rd_q, rd_d;
   logic acc, wr, rd;
   logic [15:0] sw;

   assign acc = I_PSEL && I_PENABLE;
   assign wr = acc && I_PWRITE;
   assign rd = acc && !I_PWRITE;
   assign sw = LINK.stat_word;
   assign prev_d = {sw[DHMC_SB_FAULT], sw[DHMC_SB_TARGET], sw[DHMC_SB_HERR], sw[DHMC_SB_ATTAINED]};
   assign ev = prev_d & ~prev_q;

   always_comb begin
      sq_d = sq_q;
      cw_d = cw_q;
      mode_d = mode_q;
      mask_d = mask_q;
      irq_d = irq_q;
      // clear only what the setup cycle captured, so a late event is not lost
      if (rd && I_PADDR == DHMC_A_IRQ) irq_d = irq_q & ~rd_q[DHMC_NEV-1:0];
      irq_d = irq_d | ev; // set wins over the read clear
      // walk one step per status answer
      unique case (sq_q)
         DHMC_Q_IDLE: ;
         DHMC_Q_OFF: if (sw[DHMC_SB_SWDIS]) begin
            cw_d = DHMC_CW_SHUTDOWN;
            sq_d = DHMC_Q_SHUT;
         end
         DHMC_Q_SHUT: if ((sw & DHMC_SW_READY_MASK) == DHMC_SW_READY_ON) begin
            cw_d = DHMC_CW_SWITCH_ON;
            sq_d = DHMC_Q_SWON;
         end
         DHMC_Q_SWON: if ((sw & DHMC_SW_READY_MASK) == DHMC_SW_SWITCHED_ON) begin
            cw_d = DHMC_CW_ENABLE;
            sq_d = DHMC_Q_EN;
         end
         DHMC_Q_EN: if ((sw & DHMC_SW_OPEN_MASK) == DHMC_SW_OPEN_MASK) sq_d = DHMC_Q_IDLE;
      endcase
      if (wr) begin
         unique case (I_PADDR)
            DHMC_A_CMD: begin
               case (dhmc_op_t'(I_PWDATA[1:0]))
                  DHMC_OP_SEQ: begin
                     cw_d = DHMC_CW_DISABLE;
                     sq_d = DHMC_Q_OFF;
                  end
                  DHMC_OP_START: if (cw_q == DHMC_CW_SWITCH_ON || cw_q == DHMC_CW_ENABLE)
                     cw_d = DHMC_CW_START;
                  DHMC_OP_STOP: cw_d = DHMC_CW_SWITCH_ON;
                  default: ;
               endcase
               if (I_PWDATA[2]) cw_d = cw_d | DHMC_CW_HALT;
               else cw_d = cw_d & ~DHMC_CW_HALT;
               if (I_PWDATA[3]) cw_d = cw_d | DHMC_CW_FAULT_RST;
               else cw_d = cw_d & ~DHMC_CW_FAULT_RST;
            end
            // mode changes only while 0007 stands and status shows nn33, or while idle under 0000
            DHMC_A_MODE: if (cw_q == DHMC_CW_SWITCH_ON
               && (sw & DHMC_SW_READY_MASK) == DHMC_SW_SWITCHED_ON || sq_q == DHMC_Q_IDLE
               && cw_q == DHMC_CW_DISABLE) mode_d = I_PWDATA[15:0];
            DHMC_A_MASK: mask_d = I_PWDATA[DHMC_NEV-1:0];
            default: ;
         endcase
      end
      rd_d = 32'h0000_0000;
      unique case (I_PADDR)
         DHMC_A_CMD: rd_d = {16'h0000, cw_q};
         DHMC_A_MODE: rd_d = {16'h0000, mode_q};
         DHMC_A_STATUS: rd_d = {16'h0000, sw};
         DHMC_A_DISP: rd_d = {16'h0000, LINK.mode_disp};
         DHMC_A_IRQ: rd_d = {28'h0000000, irq_q};
         DHMC_A_MASK: rd_d = {28'h0000000, mask_q};
         default: ;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sq_q <= DHMC_Q_IDLE;
         cw_q <= DHMC_CW_DISABLE;
         mode_q <= DHMC_MODE_HOMING;
         irq_q <= '0;
         mask_q <= '0;
         prev_q <= '0;
         rd_q <= 32'h0000_0000;
      end else begin
         sq_q <= sq_d;
         cw_q <= cw_d;
         mode_q <= mode_d;
         irq_q <= irq_d;
         mask_q <= mask_d;
         prev_q <= prev_d;
         rd_q <= rd_d;
      end
   end

   // read data registered in setup, so the answer is ready in access
   assign O_PRDATA = rd_q;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = 1'b0;
   assign O_IRQ = |(irq_q & mask_q);
   assign LINK.ctrl_word = cw_q;
   assign LINK.mode_sel = mode_q;
endmodule // dhmc_plc
